/* hw/sgp_pkg.sv */
package sgp_pkg;
  // ==========================================================
  // gain set switching
  localparam logic [2:0]  GAIN_SRC_ACTUAL_SPEED   = 3'h4;
  localparam logic [31:0] GAIN_SPEED_THR_RST      = 32'h0000_0064; // 100 rpm
  localparam logic [15:0] SMOOTH_TIME_MS_RST      = 16'h0014;      // 20 ms
  localparam logic [15:0] SMOOTH_TIME_MS_MIN      = 16'h0008;      // 8 ms
  localparam logic [15:0] SMOOTH_TIME_MS_MAX      = 16'h03e8;      // 1000 ms
  // second and first gain set defaults, fixed point x100 / integer ms
  localparam logic [31:0] POS_GAIN2_RST           = 32'h0000_0064; // 1.00
  localparam logic [31:0] SPD_GAIN2_RST           = 32'h0000_001e; // 0.3
  localparam logic [31:0] INT_TIME2_RST           = 32'h0000_0014; // 20 ms
  localparam logic [31:0] SPD_GAIN1_RST           = 32'h0000_001e; // 0.3
  localparam logic [31:0] INT_TIME1_RST           = 32'h0000_000f; // 15 ms
  // ==========================================================
  // pi to p switching sources
  localparam logic [2:0]  PIP_SRC_OFF             = 3'h0;
  localparam logic [2:0]  PIP_SRC_TORQUE          = 3'h1;
  localparam logic [2:0]  PIP_SRC_INPUT           = 3'h2;
  localparam logic [2:0]  PIP_SRC_SPEED           = 3'h3;
  localparam logic [2:0]  PIP_SRC_ACCEL           = 3'h4;
  localparam logic [2:0]  PIP_SRC_DEVIATION       = 3'h5;
  localparam logic [31:0] PIP_TORQUE_THR_RST      = 32'h0000_00c8; // 200 %
  localparam logic [31:0] PIP_SPEED_THR_RST       = 32'h0000_07d0; // 2000 rpm
  localparam logic [31:0] PIP_ACCEL_THR_RST       = 32'h0000_0014; // 20 rev/s2
  localparam logic [31:0] PIP_DEV_THR_RST         = 32'h0000_7530; // 30000
  // ==========================================================
  // timing at 10 MHz
  localparam int          CLK_HZ                  = 10_000_000;
  localparam int          CYC_PER_MS              = CLK_HZ / 1000;
  localparam int          FILTER_TIME_MS          = 10;
  localparam int          FILTER_CYCLES           = FILTER_TIME_MS * CYC_PER_MS;
  localparam int          PIP_DELAY_MS            = 2;
  localparam int          PIP_DELAY_CYCLES        = PIP_DELAY_MS * CYC_PER_MS;
  localparam int          CTRL_PERIOD_US          = 125;
  localparam int          CTRL_CYCLES             = CTRL_PERIOD_US * CLK_HZ / 1_000_000;
  localparam logic [7:0]  BLEND_FULL              = 8'hff;
endpackage

/* hw/sgp_switch.sv */
`timescale 1ns/1ps
// Function
// - gain source 4 compares actual speed against speed threshold, default 100
// - in speed mode, below threshold use gain set one, otherwise gain set two; other modes always use set one
// - smooth every gain set change with 8 to 1000 ms time constant
// - two gain sets; second defaults 1.00, 0.3, 20 ms
// - no proportional-only switching in torque control mode
// - proportional-only only when auto tuning and gain switching are off
// - proportional-only decision takes effect after a few milliseconds delay
// - condition true gives P control, else PI control
// - source 0 off, 1 torque, 2 input, 3 speed, 4 accel, 5 deviation
// - source 1 switches when torque setpoint exceeds threshold, default 200
// - source 2 input level 0 gives PI, level 1 gives P
// - source 3 switches when speed setpoint exceeds threshold, default 2000
// - source 4 switches when acceleration exceeds threshold, default 20
// - P switching uses set one speed gain 0.3 and integral 15 ms
// - source 5 switches when pulse deviation exceeds threshold, default 30000
// - gain change input pulses under 10 ms are ignored
module sgp_switch
  import sgp_pkg::*;
#(
  parameter int FILTER_CNT = FILTER_CYCLES,
  parameter int DELAY_CNT  = PIP_DELAY_CYCLES,
  parameter int CTRL_CNT   = CTRL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        torque_mode,
  input  wire logic        speed_mode,
  input  wire logic        auto_tune_on,
  input  wire logic [2:0]  gain_switch_source_select,
  input  wire logic [2:0]  pi_to_p_source_select,
  input  wire logic [31:0] gain_switch_speed_threshold,
  input  wire logic [15:0] gain_transition_smoothing_time,
  input  wire logic [31:0] pi_to_p_torque_threshold,
  input  wire logic [31:0] pi_to_p_speed_threshold,
  input  wire logic [31:0] pi_to_p_accel_threshold,
  input  wire logic [31:0] pi_to_p_deviation_threshold,
  input  wire logic [31:0] actual_speed,
  input  wire logic [31:0] torque_setpoint,
  input  wire logic [31:0] speed_setpoint,
  input  wire logic [31:0] acceleration,
  input  wire logic [31:0] pulse_deviation,
  input  wire logic        gain_change_in,
  output logic             gain_set_two,
  output logic [7:0]       gain_blend,
  output logic             p_only,
  output logic             ctrl_tick
);
  // ==========================================================
  // input synchroniser and 10 ms pulse filter
  logic [2:0]  gc_sync;
  logic        gc_level;
  logic [31:0] gc_cnt;
  logic [2:0]  next_gc_sync;
  logic        next_gc_level;
  logic [31:0] next_gc_cnt;
  always_comb begin
    next_gc_sync  = {gc_sync[1:0], gain_change_in};
    next_gc_level = gc_level;
    next_gc_cnt   = 32'h0;
    if (gc_sync[2] == gc_sync[1] && gc_sync[2] != gc_level) begin
      next_gc_cnt = gc_cnt + 32'h1;
      if (gc_cnt >= 32'(FILTER_CNT - 1)) begin
        next_gc_level = gc_sync[2];
        next_gc_cnt   = 32'h0;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gc_sync  <= 3'h0;
      gc_level <= 1'b0;
      gc_cnt   <= 32'h0;
    end else begin
      gc_sync  <= next_gc_sync;
      gc_level <= next_gc_level;
      gc_cnt   <= next_gc_cnt;
    end
  end

  // ==========================================================
  // control cycle tick
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic        next_ctrl_tick;
  always_comb begin
    next_ctrl_tick = (tick_cnt == 16'(CTRL_CNT - 1));
    next_tick_cnt  = next_ctrl_tick ? 16'h0 : tick_cnt + 16'h1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt  <= 16'h0;
      ctrl_tick <= 1'b0;
    end else begin
      tick_cnt  <= next_tick_cnt;
      ctrl_tick <= next_ctrl_tick;
    end
  end

  // ==========================================================
  // magnitudes and comparisons
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? 32'(-v) : v;
  endfunction

  logic gain_cond;
  logic pip_cond;
  logic pip_allowed;
  always_comb begin
    gain_cond = speed_mode && (gain_switch_source_select == GAIN_SRC_ACTUAL_SPEED)
                && (mag(actual_speed) >= gain_switch_speed_threshold);
  end
  always_comb begin
    case (pi_to_p_source_select)
      PIP_SRC_TORQUE:    pip_cond = mag(torque_setpoint) > pi_to_p_torque_threshold;
      PIP_SRC_INPUT:     pip_cond = gc_level;
      PIP_SRC_SPEED:     pip_cond = mag(speed_setpoint) > pi_to_p_speed_threshold;
      PIP_SRC_ACCEL:     pip_cond = mag(acceleration) > pi_to_p_accel_threshold;
      PIP_SRC_DEVIATION: pip_cond = mag(pulse_deviation) > pi_to_p_deviation_threshold;
      default:           pip_cond = 1'b0;
    endcase
  end
  assign pip_allowed = !torque_mode && !auto_tune_on && (gain_switch_source_select == 3'h0);

  // ==========================================================
  // decision registers, delay and smoothing
  logic        pip_req;
  logic [31:0] dly_cnt;
  logic [31:0] sm_cnt;
  logic [31:0] sm_step;
  logic        next_gain_set_two;
  logic        next_pip_req;
  logic [31:0] next_dly_cnt;
  logic        next_p_only;
  logic [31:0] next_sm_cnt;
  logic [7:0]  next_gain_blend;
  always_comb begin
    logic [15:0] tc;
    tc = gain_transition_smoothing_time;
    if (tc < SMOOTH_TIME_MS_MIN) tc = SMOOTH_TIME_MS_MIN;
    if (tc > SMOOTH_TIME_MS_MAX) tc = SMOOTH_TIME_MS_MAX;
    // cycles per blend step: tc ms spread over 255 steps
    sm_step = 32'(tc) * 32'(CYC_PER_MS) / 32'h0000_00ff;
    next_gain_set_two = gain_set_two;
    next_pip_req      = pip_req;
    if (ctrl_tick) begin
      next_gain_set_two = gain_cond;
      next_pip_req      = pip_allowed && pip_cond;
    end
    // delayed P engagement, set one gains
    next_p_only  = p_only;
    next_dly_cnt = 32'h0;
    if (!pip_req) begin
      next_p_only = 1'b0;
    end else if (!p_only) begin
      next_dly_cnt = dly_cnt + 32'h1;
      if (dly_cnt >= 32'(DELAY_CNT - 1)) next_p_only = 1'b1;
    end
    next_gain_blend = gain_blend;
    next_sm_cnt     = sm_cnt + 32'h1;
    if (sm_cnt >= sm_step) begin
      next_sm_cnt = 32'h0;
      if (gain_set_two && gain_blend != BLEND_FULL) next_gain_blend = gain_blend + 8'h1;
      if (!gain_set_two && gain_blend != 8'h0) next_gain_blend = gain_blend - 8'h1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_set_two <= 1'b0;
      pip_req      <= 1'b0;
      dly_cnt      <= 32'h0;
      p_only       <= 1'b0;
      sm_cnt       <= 32'h0;
      gain_blend   <= 8'h0;
    end else begin
      gain_set_two <= next_gain_set_two;
      pip_req      <= next_pip_req;
      dly_cnt      <= next_dly_cnt;
      p_only       <= next_p_only;
      sm_cnt       <= next_sm_cnt;
      gain_blend   <= next_gain_blend;
    end
  end

  // ==========================================================
  // checks
  a_torque_no_p: assert property (@(posedge clk) disable iff (!rstn)
    torque_mode && ctrl_tick |=> !pip_req)
    else $error("p request in torque mode");
  a_tune_no_p: assert property (@(posedge clk) disable iff (!rstn)
    (auto_tune_on || gain_switch_source_select != 3'h0) && ctrl_tick |=> !pip_req)
    else $error("p request while tuning or gain switching");
  a_p_delayed: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pip_req) |-> !p_only ##1 !p_only)
    else $error("p control engaged without delay");
  a_p_release: assert property (@(posedge clk) disable iff (!rstn)
    !pip_req |=> !p_only)
    else $error("p control held after condition left");
  a_gain_speed: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_tick && gain_cond |=> gain_set_two)
    else $error("second gain set not chosen");
  a_gain_low: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_tick && (!speed_mode || gain_switch_source_select != GAIN_SRC_ACTUAL_SPEED)
    |=> !gain_set_two)
    else $error("first gain set not chosen");
  a_blend_step: assert property (@(posedge clk) disable iff (!rstn)
    gain_blend != $past(gain_blend) |-> $past(sm_cnt) >= $past(sm_step))
    else $error("blend moved off step");
  a_input_filter: assert property (@(posedge clk) disable iff (!rstn)
    $changed(gc_level) |-> $past(gc_cnt) >= 32'(FILTER_CNT - 1))
    else $error("input accepted before filter time");
  a_off_source: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_tick && pi_to_p_source_select == PIP_SRC_OFF |=> !pip_req)
    else $error("p request with source off");
endmodule

/* sim/sgp_switch_tb.sv */
`timescale 1ns/1ps
module sgp_switch_tb;
  import sgp_pkg::*;
  // ==========================================================
  // shortened counts, stimulus and counters
  localparam int FC = 20;
  localparam int DC = 5;
  localparam int CC = 8;
  logic        clk, rstn, tm, sm, at, gin, gs2, po, tick;
  logic [2:0]  gsel, psel;
  logic [15:0] smt;
  logic [7:0]  blend;
  logic [31:0] gthr, tthr, sthr, athr, dthr, asp, tq, sp, acc, dev;
  int          mismatches, total_checks, n;

  sgp_switch #(.FILTER_CNT(FC), .DELAY_CNT(DC), .CTRL_CNT(CC)) uut (
    .clk(clk), .rstn(rstn), .torque_mode(tm), .speed_mode(sm), .auto_tune_on(at),
    .gain_switch_source_select(gsel), .pi_to_p_source_select(psel),
    .gain_switch_speed_threshold(gthr), .gain_transition_smoothing_time(smt),
    .pi_to_p_torque_threshold(tthr), .pi_to_p_speed_threshold(sthr),
    .pi_to_p_accel_threshold(athr), .pi_to_p_deviation_threshold(dthr),
    .actual_speed(asp), .torque_setpoint(tq), .speed_setpoint(sp), .acceleration(acc),
    .pulse_deviation(dev), .gain_change_in(gin), .gain_set_two(gs2), .gain_blend(blend),
    .p_only(po), .ctrl_tick(tick));

  // free running 10 mhz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // reference model and helpers
  function automatic longint mag(logic [31:0] v);
    return v[31] ? -longint'($signed(v)) : longint'(v);
  endfunction

  // proportional-only decision worked out from the inputs
  function automatic bit exp_p();
    bit m;
    case (psel)
      PIP_SRC_TORQUE:    m = mag(tq) > tthr;
      PIP_SRC_INPUT:     m = gin;
      PIP_SRC_SPEED:     m = mag(sp) > sthr;
      PIP_SRC_ACCEL:     m = mag(acc) > athr;
      PIP_SRC_DEVIATION: m = mag(dev) > dthr;
      default:           m = 1'b0;
    endcase
    return m && !tm && !at && gsel == 3'h0;
  endfunction

  // value near a threshold, either sign, or anything
  function automatic logic [31:0] pick(logic [31:0] t);
    case ($urandom_range(0, 4))
      0:       return t - 1;
      1:       return t;
      2:       return t + 1;
      3:       return -(t + 1);
      default: return $urandom;
    endcase
  endfunction

  task automatic check(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // bounded wait for the next control tick
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tick !== 1'b1 && c < 100);
    if (c >= 100) begin
      check(1'b0, "control tick missing");
      complete_run();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h8c4e6592));
    {rstn, tm, at, gin, gsel, psel} = '0;
    sm = 1'b1;
    smt = SMOOTH_TIME_MS_MIN;
    {gthr, tthr, sthr} = {GAIN_SPEED_THR_RST, PIP_TORQUE_THR_RST, PIP_SPEED_THR_RST};
    {athr, dthr} = {PIP_ACCEL_THR_RST, PIP_DEV_THR_RST};
    {asp, tq, sp, acc, dev} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(gs2 === 1'b0 && blend === 8'h00 && po === 1'b0, "reset outputs");
    check(POS_GAIN2_RST === 32'h64 && SPD_GAIN2_RST === 32'h1e, "set two gains");
    check(INT_TIME2_RST === 32'h14 && INT_TIME1_RST === 32'h0f, "integral times");
    wait_tick(n);
    wait_tick(n);
    check(n == CC, "control tick period");
    // negative speed of exactly threshold magnitude selects set two, ramped
    @(posedge clk);
    gsel <= GAIN_SRC_ACTUAL_SPEED;
    asp <= -GAIN_SPEED_THR_RST;
    step(40);
    check(gs2 === 1'b1, "gain set two at threshold");
    step(2000);
    check(blend > 8'h00 && blend < BLEND_FULL, "blend not smoothed");
    // every source against every blocking condition, random values
    for (int i = 0; i < 48; i++) begin
      @(posedge clk);
      psel <= 3'(i % 6);
      tm <= (i / 6) % 8 == 1;
      at <= (i / 6) % 8 == 2;
      sm <= (i / 6) % 8 != 4;
      gsel <= ((i / 6) % 8 inside {3, 4}) ? GAIN_SRC_ACTUAL_SPEED : 3'h0;
      gthr <= $urandom_range(0, 5000);
      tthr <= $urandom_range(0, 300);
      sthr <= $urandom_range(0, 210000);
      athr <= $urandom_range(0, 30000);
      dthr <= $urandom_range(0, 100000);
      gin <= 1'($urandom_range(0, 1));
      @(posedge clk);
      asp <= pick(gthr);
      tq <= pick(tthr);
      sp <= pick(sthr);
      acc <= pick(athr);
      dev <= pick(dthr);
      step(80);
      check(po === exp_p(), "p only decision");
      check(gs2 === (sm && gsel == GAIN_SRC_ACTUAL_SPEED && mag(asp) >= gthr), "gain set");
    end
    // short input pulse is filtered, a long one switches
    @(posedge clk);
    {tm, at, gsel, gin} <= '0;
    psel <= PIP_SRC_INPUT;
    step(80);
    @(posedge clk);
    gin <= 1'b1;
    step(FC / 2);
    @(posedge clk);
    gin <= 1'b0;
    step(80);
    check(po === 1'b0, "short pulse switched");
    @(posedge clk);
    gin <= 1'b1;
    step(80);
    check(po === 1'b1, "input level one");
    // torque crossing takes effect only after the delay
    @(posedge clk);
    psel <= PIP_SRC_TORQUE;
    tthr <= PIP_TORQUE_THR_RST;
    tq <= 32'h0;
    step(80);
    @(posedge clk);
    tq <= PIP_TORQUE_THR_RST + 1;
    step(DC);
    check(po === 1'b0, "p only too early");
    step(80);
    check(po === 1'b1, "torque above threshold");
    complete_run();
  end
endmodule
